// file: include/xcvr_pkg.sv
`default_nettype none
package xcvr_pkg;
    // clock and timing
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned DIS_HOLD_US = 10;
    localparam int unsigned DIS_HOLD_CYC = DIS_HOLD_US * CLK_MHZ;
    localparam int unsigned SERIAL_READY_MS = 300;
    localparam int unsigned SERIAL_READY_CYC_DEF =
        SERIAL_READY_MS * 1000 * CLK_MHZ;
    localparam int unsigned HOLD_W = 11;
    localparam int unsigned READY_W = 32;

    // serial bus device addresses, 7-bit form
    localparam logic [6:0] DEV_ID = 7'h50;
    localparam logic [6:0] DEV_DIAG = 7'h51;

    // register offsets in the diagnostic map
    localparam logic [7:0] OFS_CTL = 8'h6E;
    localparam logic [7:0] OFS_EXT = 8'h76;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // control/status byte fields
    localparam int CTL_HW_DIS = 7;
    localparam int CTL_SOFT_DIS = 6;
    localparam int CTL_HW_SS2 = 5;
    localparam int CTL_HW_SS1 = 4;
    localparam int CTL_SOFT_SS1 = 3;
    localparam int CTL_FAULT = 2;
    localparam int CTL_LOST = 1;
    localparam int CTL_READY = 0;
    // extended control byte field
    localparam int EXT_SOFT_SS2 = 3;

    // positions in the synchronised input vector
    localparam int IN_SCL = 0;
    localparam int IN_SDA = 1;
    localparam int IN_DIS = 2;
    localparam int IN_SS1 = 3;
    localparam int IN_SS2 = 4;
    localparam int IN_FLT = 5;
    localparam int IN_SIG = 6;
    localparam int IN_MON = 7;
    localparam int IN_W = 8;

    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // serial bus slave states
    typedef enum logic [2:0] {
        st_idle,
        st_dev,
        st_word,
        st_wdata,
        st_rdata
    } bus_state_t;

    // analog front end status toward the logic
    typedef struct packed {
        logic monitor_ok;
        logic signal_present;
        logic laser_fault_detect;
    } optics_in_t;

    // controls toward laser driver and recovery circuits
    typedef struct packed {
        logic laser_enable;
        logic first_cdr_engage;
        logic second_cdr_engage;
    } optics_out_t;
endpackage : xcvr_pkg
`default_nettype wire

// file: logic/transceiver_ctrl_status_timing.sv
// Functional notes
// - hardware laser-off rise kills light within 10us
// - hardware laser-off fall restores light within 1ms
// - initialization done within 300ms, fault cleared
// - laser fault pin raised within 100us
// - signal-lost pin raised within 100us of loss
// - signal-lost pin dropped within 100us of return
// - speed select high engages recovery within 1ms
// - speed select low bypasses recovery within 1ms
// - soft laser-off bit kills light within 100ms
// - clearing soft laser-off restores light within 100ms
// - soft fault bit set within 100ms
// - soft signal-lost bit tracks input within 100ms
// - soft speed bits steer recovery within 100ms
// - data-ready bit set within 1000ms
// - serial bus usable within 300ms of power-on
// - internal write finishes within 40ms or 80ms
`default_nettype none
module transceiver_ctrl_status_timing #(
    parameter int unsigned SERIAL_READY_CYC = xcvr_pkg::SERIAL_READY_CYC_DEF
) (
    // clock and power-on reset
    input wire logic clk,
    input wire logic rst_b,
    // host pins
    input wire logic tx_disable,
    input wire logic first_speed_select,
    input wire logic second_speed_select,
    output logic laser_fault,
    output logic signal_lost_flag,
    // two-wire serial bus, open drain data
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // optics side
    input wire xcvr_pkg::optics_in_t optics,
    output xcvr_pkg::optics_out_t ctrl
);
    localparam int W = xcvr_pkg::IN_W;

    // three-stage synchroniser with agreement filter
    logic [W-1:0] raw, s1, s2, s3, stable, prev;
    logic [W-1:0] next_s1, next_s2, next_s3, next_stable, next_prev;

    assign raw = {optics.monitor_ok, optics.signal_present,
                  optics.laser_fault_detect, second_speed_select,
                  first_speed_select, tx_disable, sda_in, scl};

    // a bit moves only once the two later stages agree
    always_comb begin
        next_s1 = raw;
        next_s2 = s1;
        next_s3 = s2;
        next_prev = stable;
        for (int i = 0; i < W; i++) begin
            next_stable[i] = (s2[i] == s3[i]) ? s2[i] : stable[i];
        end
    end

    // scl/sda idle high, so they reset high to avoid a false start
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1 <= 8'h03;
            s2 <= 8'h03;
            s3 <= 8'h03;
            stable <= 8'h03;
            prev <= 8'h03;
        end else begin
            s1 <= next_s1;
            s2 <= next_s2;
            s3 <= next_s3;
            stable <= next_stable;
            prev <= next_prev;
        end
    end

    // bus conditions seen on the filtered lines
    logic scl_rise, scl_fall, bus_start, bus_stop, sda_now;
    assign sda_now = stable[xcvr_pkg::IN_SDA];
    assign scl_rise = stable[xcvr_pkg::IN_SCL] & ~prev[xcvr_pkg::IN_SCL];
    assign scl_fall = ~stable[xcvr_pkg::IN_SCL] & prev[xcvr_pkg::IN_SCL];
    assign bus_start = stable[xcvr_pkg::IN_SCL] & prev[xcvr_pkg::IN_SCL]
                       & prev[xcvr_pkg::IN_SDA] & ~sda_now;
    assign bus_stop = stable[xcvr_pkg::IN_SCL] & prev[xcvr_pkg::IN_SCL]
                      & ~prev[xcvr_pkg::IN_SDA] & sda_now;

    logic dis_now, dis_fall;
    assign dis_now = stable[xcvr_pkg::IN_DIS];
    assign dis_fall = ~dis_now & prev[xcvr_pkg::IN_DIS];

    // control state
    logic [xcvr_pkg::READY_W-1:0] ready_cnt, next_ready_cnt;
    logic bus_ready, next_bus_ready;
    logic [xcvr_pkg::HOLD_W-1:0] hold_cnt, next_hold_cnt;
    logic fault_lat, next_fault_lat;
    logic soft_dis, soft_ss1, soft_ss2;
    logic next_soft_dis, next_soft_ss1, next_soft_ss2;
    logic next_laser_fault, next_lost, next_ready_bit, data_ready;
    xcvr_pkg::optics_out_t next_ctrl;

    // staged write data, applied at the stop condition
    logic stg_dis, stg_ss1, stg_ss2, stg_ctl, stg_ext;
    logic commit_ctl, commit_ext;

    always_comb begin
        // bus stays deaf until the power-on settle time expires
        next_ready_cnt = ready_cnt;
        next_bus_ready = bus_ready;
        if (ready_cnt >= (xcvr_pkg::READY_W)'(SERIAL_READY_CYC)) begin
            next_bus_ready = 1'b1;
        end else begin
            next_ready_cnt = ready_cnt + 32'h0000_0001;
        end
        // time how long laser-off has been held high
        next_hold_cnt = hold_cnt;
        if (!dis_now) begin
            next_hold_cnt = '0;
        end else if (hold_cnt < (xcvr_pkg::HOLD_W)'(xcvr_pkg::DIS_HOLD_CYC)) begin
            next_hold_cnt = hold_cnt + 11'h001;
        end
        // a new fault wins over a clear in the same cycle
        next_fault_lat = fault_lat;
        if (dis_fall
            && hold_cnt >= (xcvr_pkg::HOLD_W)'(xcvr_pkg::DIS_HOLD_CYC)) begin
            next_fault_lat = 1'b0;
        end
        if (stable[xcvr_pkg::IN_FLT]) begin
            next_fault_lat = 1'b1;
        end
        // soft bits update when a write is committed
        next_soft_dis = commit_ctl ? stg_dis : soft_dis;
        next_soft_ss1 = commit_ctl ? stg_ss1 : soft_ss1;
        next_soft_ss2 = commit_ext ? stg_ss2 : soft_ss2;
        next_laser_fault = next_fault_lat;
        next_lost = ~stable[xcvr_pkg::IN_SIG];
        next_ready_bit = stable[xcvr_pkg::IN_MON];
        // light needs no request, no soft request and no fault
        next_ctrl.laser_enable = ~dis_now & ~next_soft_dis
                                 & ~next_fault_lat;
        next_ctrl.first_cdr_engage = stable[xcvr_pkg::IN_SS1]
                                     | next_soft_ss1;
        next_ctrl.second_cdr_engage = stable[xcvr_pkg::IN_SS2]
                                      | next_soft_ss2;
    end

    // power-on reset clears the fault and starts initialization
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ready_cnt <= '0;
            bus_ready <= 1'b0;
            hold_cnt <= '0;
            fault_lat <= 1'b0;
            soft_dis <= 1'b0;
            soft_ss1 <= 1'b0;
            soft_ss2 <= 1'b0;
            laser_fault <= 1'b0;
            signal_lost_flag <= 1'b1;
            data_ready <= 1'b0;
            ctrl <= '0;
        end else begin
            ready_cnt <= next_ready_cnt;
            bus_ready <= next_bus_ready;
            hold_cnt <= next_hold_cnt;
            fault_lat <= next_fault_lat;
            soft_dis <= next_soft_dis;
            soft_ss1 <= next_soft_ss1;
            soft_ss2 <= next_soft_ss2;
            laser_fault <= next_laser_fault;
            signal_lost_flag <= next_lost;
            data_ready <= next_ready_bit;
            ctrl <= next_ctrl;
        end
    end

    // register read view
    logic [7:0] ctl_byte, ext_byte;
    always_comb begin
        ctl_byte = xcvr_pkg::BYTE_ZERO;
        ctl_byte[xcvr_pkg::CTL_HW_DIS] = dis_now;
        ctl_byte[xcvr_pkg::CTL_SOFT_DIS] = soft_dis;
        ctl_byte[xcvr_pkg::CTL_HW_SS2] = stable[xcvr_pkg::IN_SS2];
        ctl_byte[xcvr_pkg::CTL_HW_SS1] = stable[xcvr_pkg::IN_SS1];
        ctl_byte[xcvr_pkg::CTL_SOFT_SS1] = soft_ss1;
        ctl_byte[xcvr_pkg::CTL_FAULT] = fault_lat;
        ctl_byte[xcvr_pkg::CTL_LOST] = signal_lost_flag;
        ctl_byte[xcvr_pkg::CTL_READY] = data_ready;
        ext_byte = xcvr_pkg::BYTE_ZERO;
        ext_byte[xcvr_pkg::EXT_SOFT_SS2] = soft_ss2;
    end

    // serial bus slave state
    xcvr_pkg::bus_state_t state, next_state;
    logic [3:0] bitcnt, next_bitcnt;
    logic [7:0] shreg, next_shreg, ptr, next_ptr, rd_byte;
    logic ack_phase, next_ack_phase, sel_diag, next_sel_diag;
    logic next_sda_oe;
    logic next_stg_dis, next_stg_ss1, next_stg_ss2;
    logic next_stg_ctl, next_stg_ext;

    // identity memory is held elsewhere, so it reads as zero here
    always_comb begin
        if (!sel_diag) begin
            rd_byte = xcvr_pkg::BYTE_ZERO;
        end else if (ptr == xcvr_pkg::OFS_CTL) begin
            rd_byte = ctl_byte;
        end else if (ptr == xcvr_pkg::OFS_EXT) begin
            rd_byte = ext_byte;
        end else begin
            rd_byte = xcvr_pkg::BYTE_ZERO;
        end
    end

    assign commit_ctl = bus_stop & stg_ctl;
    assign commit_ext = bus_stop & stg_ext;

    always_comb begin
        next_state = state;
        next_bitcnt = bitcnt;
        next_shreg = shreg;
        next_ptr = ptr;
        next_ack_phase = ack_phase;
        next_sel_diag = sel_diag;
        next_sda_oe = sda_oe;
        next_stg_dis = stg_dis;
        next_stg_ss1 = stg_ss1;
        next_stg_ss2 = stg_ss2;
        next_stg_ctl = stg_ctl;
        next_stg_ext = stg_ext;
        if (bus_start) begin
            // a repeated start keeps staged data until the stop
            next_state = xcvr_pkg::st_dev;
            next_bitcnt = '0;
            next_ack_phase = 1'b0;
            next_sda_oe = 1'b0;
        end else if (bus_stop) begin
            // staged bytes go live right here, far inside the limit
            next_state = xcvr_pkg::st_idle;
            next_sda_oe = 1'b0;
            next_stg_ctl = 1'b0;
            next_stg_ext = 1'b0;
        end else if (state == xcvr_pkg::st_idle) begin
            next_sda_oe = 1'b0;
        end else if (scl_rise) begin
            if (ack_phase) begin
                // master nack ends a read
                if (state == xcvr_pkg::st_rdata && sda_now) begin
                    next_state = xcvr_pkg::st_idle;
                end
            end else if (bitcnt < xcvr_pkg::BITS_PER_BYTE) begin
                next_shreg = {shreg[6:0], sda_now};
                next_bitcnt = bitcnt + 4'h1;
            end
        end else if (scl_fall) begin
            if (ack_phase) begin
                next_ack_phase = 1'b0;
                next_bitcnt = '0;
                next_sda_oe = 1'b0;
                if (state == xcvr_pkg::st_rdata) begin
                    next_shreg = rd_byte;
                    next_sda_oe = ~rd_byte[7];
                end
            end else if (bitcnt == xcvr_pkg::BITS_PER_BYTE) begin
                next_ack_phase = 1'b1;
                next_sda_oe = 1'b1;
                case (state)
                    xcvr_pkg::st_dev: begin
                        if (bus_ready && (shreg[7:1] == xcvr_pkg::DEV_ID
                            || shreg[7:1] == xcvr_pkg::DEV_DIAG)) begin
                            next_sel_diag = shreg[7:1] == xcvr_pkg::DEV_DIAG;
                            next_state = shreg[0] ? xcvr_pkg::st_rdata
                                                  : xcvr_pkg::st_word;
                        end else begin
                            next_state = xcvr_pkg::st_idle;
                            next_sda_oe = 1'b0;
                        end
                    end
                    xcvr_pkg::st_word: begin
                        next_ptr = shreg;
                        next_state = xcvr_pkg::st_wdata;
                    end
                    xcvr_pkg::st_wdata: begin
                        if (sel_diag && ptr == xcvr_pkg::OFS_CTL) begin
                            next_stg_dis = shreg[xcvr_pkg::CTL_SOFT_DIS];
                            next_stg_ss1 = shreg[xcvr_pkg::CTL_SOFT_SS1];
                            next_stg_ctl = 1'b1;
                        end else if (sel_diag && ptr == xcvr_pkg::OFS_EXT) begin
                            next_stg_ss2 = shreg[xcvr_pkg::EXT_SOFT_SS2];
                            next_stg_ext = 1'b1;
                        end
                        next_ptr = ptr + 8'h01;
                    end
                    xcvr_pkg::st_rdata: begin
                        // release the line for the master's ack
                        next_sda_oe = 1'b0;
                        next_ptr = ptr + 8'h01;
                    end
                    default: begin
                        next_state = xcvr_pkg::st_idle;
                        next_sda_oe = 1'b0;
                    end
                endcase
            end else if (state == xcvr_pkg::st_rdata) begin
                next_sda_oe = ~shreg[7];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= xcvr_pkg::st_idle;
            bitcnt <= '0;
            shreg <= '0;
            ptr <= '0;
            ack_phase <= 1'b0;
            sel_diag <= 1'b0;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
            stg_dis <= 1'b0;
            stg_ss1 <= 1'b0;
            stg_ss2 <= 1'b0;
            stg_ctl <= 1'b0;
            stg_ext <= 1'b0;
        end else begin
            state <= next_state;
            bitcnt <= next_bitcnt;
            shreg <= next_shreg;
            ptr <= next_ptr;
            ack_phase <= next_ack_phase;
            sel_diag <= next_sel_diag;
            sda_oe <= next_sda_oe;
            sda_out <= 1'b0; // open drain only ever pulls low
            stg_dis <= next_stg_dis;
            stg_ss1 <= next_stg_ss1;
            stg_ss2 <= next_stg_ss2;
            stg_ctl <= next_stg_ctl;
            stg_ext <= next_stg_ext;
        end
    end
endmodule : transceiver_ctrl_status_timing
`default_nettype wire

// file: tb/xcvr_ctrl_checker.sv
`default_nettype none
module xcvr_ctrl_checker #(
    parameter int unsigned SERIAL_READY_CYC = 50
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // host pins
    input wire logic tx_disable,
    input wire logic first_speed_select,
    input wire logic laser_fault,
    input wire logic signal_lost_flag,
    input wire logic scl,
    input wire logic sda_oe,
    // optics side
    input wire xcvr_pkg::optics_in_t optics,
    input wire xcvr_pkg::optics_out_t ctrl
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] age, next_age;
    logic [3:0] low_cnt, next_low_cnt;
    default clocking dcb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // both saturate so a long run never wraps into a false window
    always_comb begin
        next_age = (age == 32'hFFFFFFFF) ? age : age + 32'h1;
        next_low_cnt = (low_cnt == 4'hF) ? low_cnt : low_cnt + 4'h1;
        if (tx_disable) begin
            next_low_cnt = 4'h0;
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            age <= 32'h0;
            low_cnt <= 4'h0;
        end else begin
            age <= next_age;
            low_cnt <= next_low_cnt;
        end
    end
    a_hw_off: assert property ($rose(tx_disable) |-> ##[1:6] !ctrl.laser_enable)
        else $error("laser not off after laser-off pin rose");
    a_fault_pin: assert property ($rose(optics.laser_fault_detect) |-> ##[1:6] laser_fault)
        else $error("fault pin late");
    // a fault may only clear while the pin is high or in the few cycles after it falls
    a_fault_latch: assert property (laser_fault && low_cnt >= 4'h8 |=> laser_fault)
        else $error("fault dropped without laser-off pulse");
    a_loss_set: assert property ($fell(optics.signal_present) |-> ##[1:6] signal_lost_flag)
        else $error("signal-lost pin late");
    a_loss_clr: assert property ($rose(optics.signal_present) |-> ##[1:6] !signal_lost_flag)
        else $error("signal-lost pin stuck");
    a_rate_up: assert property ($rose(first_speed_select) |-> ##[1:6] ctrl.first_cdr_engage)
        else $error("first recovery not engaged");
    a_bus_quiet: assert property (age < SERIAL_READY_CYC |-> !sda_oe)
        else $error("bus answered before ready");
    a_sda_hold: assert property ($changed(sda_oe) |-> !scl)
        else $error("data line moved while clock high");
    c_fault: cover property ($rose(laser_fault));
    c_clear: cover property ($fell(laser_fault));
    c_ack: cover property ($rose(sda_oe));
endmodule : xcvr_ctrl_checker
`default_nettype wire

// file: tb/host_ctrl_model.sv
`default_nettype none
module host_ctrl_model #(
    parameter int QTR = 65
) (
    // clock and resolved data line
    input wire logic clk,
    input wire logic sda,
    // bus drive, sda_low pulls the line down
    output logic scl = 1'b1,
    output logic sda_low = 1'b0,
    // read results, one-cycle strobe
    output logic rd_valid = 1'b0,
    output logic [7:0] rd_data = 8'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    // four quarters per bit keep the clock near 385 kHz
    task automatic qtr;
        repeat (QTR) @(posedge clk);
    endtask : qtr
    // data set while clock low, sampled mid high
    task automatic bit_cyc(input logic drv, output logic got);
        sda_low <= ~drv;
        qtr();
        scl <= 1'b1;
        qtr();
        got = sda;
        qtr();
        scl <= 1'b0;
        qtr();
    endtask : bit_cyc
    task automatic start;
        sda_low <= 1'b0;
        qtr();
        scl <= 1'b1;
        qtr();
        sda_low <= 1'b1;
        qtr();
        scl <= 1'b0;
        qtr();
    endtask : start
    task automatic stop;
        sda_low <= 1'b1;
        qtr();
        scl <= 1'b1;
        qtr();
        sda_low <= 1'b0;
        repeat (2000) @(posedge clk);
    endtask : stop
    task automatic wr_byte(input logic [7:0] b, output logic nack);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(b[i], g);
        end
        bit_cyc(1'b1, nack);
    endtask : wr_byte
    task automatic rd_byte(input logic last);
        logic [7:0] v;
        logic g;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(1'b1, v[i]);
        end
        bit_cyc(last, g);
        rd_data <= v;
        rd_valid <= 1'b1;
        @(posedge clk);
        rd_valid <= 1'b0;
    endtask : rd_byte
endmodule : host_ctrl_model
`default_nettype wire

// file: tb/tb_transceiver_ctrl_status_timing.sv
`default_nettype none
module tb_transceiver_ctrl_status_timing;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic tx_disable = 1'b0;
    logic first_speed_select = 1'b0;
    logic second_speed_select = 1'b0;
    xcvr_pkg::optics_in_t optics = 3'b110;
    xcvr_pkg::optics_out_t ctrl;
    logic laser_fault, signal_lost_flag, sda_out, sda_oe, scl, sda;
    logic sda_low, rd_valid, n;
    logic [7:0] rd_data;
    logic [7:0] exp_q[$];
    logic [31:0] r;
    int errors = 0;
    int num_checks = 0;
    int seed = 9;
    // open drain line with pull-up
    assign sda = ~(sda_low | (sda_oe & ~sda_out));
    always #5 clk = ~clk;
    transceiver_ctrl_status_timing #(.SERIAL_READY_CYC(5000)) uut (
        .clk(clk), .rst_b(rst_b), .tx_disable(tx_disable),
        .first_speed_select(first_speed_select),
        .second_speed_select(second_speed_select),
        .laser_fault(laser_fault), .signal_lost_flag(signal_lost_flag),
        .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .optics(optics), .ctrl(ctrl));
    host_ctrl_model host (.clk(clk), .sda(sda), .scl(scl),
        .sda_low(sda_low), .rd_valid(rd_valid), .rd_data(rd_data));
    task automatic chk(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict
    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
    endtask : cyc
    task automatic wreg(input logic [7:0] a, input logic [7:0] v);
        logic n0, n1, n2;
        host.start();
        host.wr_byte(8'hA2, n0);
        host.wr_byte(a, n1);
        host.wr_byte(v, n2);
        host.stop();
        chk("write ack", 8'h00, {5'h00, n0, n1, n2});
        cyc(8);
    endtask : wreg
    // address phase, repeated start, one byte read then nack
    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        logic n0, n1, n2;
        exp_q.push_back(e);
        host.start();
        host.wr_byte(8'hA2, n0);
        host.wr_byte(a, n1);
        host.start();
        host.wr_byte(8'hA3, n2);
        host.rd_byte(1'b1);
        host.stop();
        chk("read ack", 8'h00, {5'h00, n0, n1, n2});
    endtask : rreg
    task automatic pulse_dis(input int c);
        @(posedge clk);
        tx_disable <= 1'b1;
        cyc(c);
        tx_disable <= 1'b0;
        cyc(8);
    endtask : pulse_dis
    // read watcher pairs each returned byte with the oldest note
    always @(posedge clk) begin
        if (rd_valid === 1'b1) begin
            chk("read", exp_q.size() > 0 ? exp_q.pop_front() : ~rd_data, rd_data);
        end
    end
    initial begin
        cyc(100000);
        errors++;
        print_verdict();
    end
    initial begin
        cyc(20);
        rst_b <= 1'b1;
        host.start();
        host.wr_byte(8'hA2, n);
        host.stop();
        chk("early ack", 8'h01, n);
        for (int k = 0; k < 6; k++) begin
            r = $random(seed);
            @(posedge clk);
            first_speed_select <= r[0];
            second_speed_select <= r[1];
            cyc(8);
            chk("cdr1", r[0], ctrl.first_cdr_engage);
            chk("cdr2", r[1], ctrl.second_cdr_engage);
        end
        first_speed_select <= 1'b0;
        second_speed_select <= 1'b0;
        pulse_dis(20);
        chk("laser on", 8'h01, ctrl.laser_enable);
        tx_disable <= 1'b1;
        cyc(8);
        chk("laser off", 8'h00, ctrl.laser_enable);
        tx_disable <= 1'b0;
        optics.signal_present <= 1'b0;
        cyc(8);
        chk("lost", 8'h01, signal_lost_flag);
        optics.signal_present <= 1'b1;
        cyc(5000);
        chk("found", 8'h00, signal_lost_flag);
        wreg(8'h6E, 8'h48);
        chk("soft off", 8'h00, ctrl.laser_enable);
        chk("soft cdr1", 8'h01, ctrl.first_cdr_engage);
        wreg(8'h76, 8'h08);
        chk("soft cdr2", 8'h01, ctrl.second_cdr_engage);
        optics <= 3'b101;
        cyc(10);
        optics.laser_fault_detect <= 1'b0;
        first_speed_select <= 1'b1;
        cyc(8);
        chk("fault pin", 8'h01, laser_fault);
        rreg(8'h6E, 8'h5F);
        rreg(8'h76, 8'h08);
        optics.signal_present <= 1'b1;
        wreg(8'h6E, 8'h00);
        chk("latched", 8'h00, ctrl.laser_enable);
        wreg(8'h76, 8'h00);
        chk("soft cdr2 off", 8'h00, ctrl.second_cdr_engage);
        pulse_dis(100);
        chk("short pulse", 8'h01, laser_fault);
        pulse_dis(1010);
        chk("fault clear", 8'h00, laser_fault);
        chk("laser back", 8'h01, ctrl.laser_enable);
        for (int i = 0; i < 100 && exp_q.size() != 0; i++) begin
            @(posedge clk);
        end
        chk("reads left", 8'h00, 8'(exp_q.size()));
        print_verdict();
    end
endmodule : tb_transceiver_ctrl_status_timing
bind transceiver_ctrl_status_timing xcvr_ctrl_checker #(
    .SERIAL_READY_CYC(SERIAL_READY_CYC)
) chk_i (.clk(clk), .rst_b(rst_b), .tx_disable(tx_disable),
    .first_speed_select(first_speed_select), .laser_fault(laser_fault),
    .signal_lost_flag(signal_lost_flag), .scl(scl), .sda_oe(sda_oe),
    .optics(optics), .ctrl(ctrl));
`default_nettype wire
